// *** ioir_redir_dev.sv ***
// Redirection table, pin detection and message launcher
`timescale 1ns/1ns
`default_nettype none
`include "ioir_defines.svh"

module ioir_redir_dev
  import ioir_pkg::*;
#(
  parameter int NUM_PINS = `IOIR_NUM_PINS
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Interrupt input pins
  input  wire logic [NUM_PINS-1:0] irq_pins,
  // Acknowledge toward the external legacy controller
  output logic             ext_ack,
  // Link to the bus-side agent
  ioir_link_if.dev         link
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (NUM_PINS < 1 || NUM_PINS > `IOIR_NUM_PINS) begin : g_bad_pins
    $error("NUM_PINS must lie between 1 and 24");
  end

  // ****************************************
  // Storage
  // ****************************************
  logic [NUM_PINS-1:0] sync1_q;
  logic [NUM_PINS-1:0] sync2_q;
  logic [7:0]          vec_q   [NUM_PINS];
  ioir_mode_t          mode_q  [NUM_PINS];
  logic [7:0]          dest_q  [NUM_PINS];
  logic [7:0]          extended_destination_q  [NUM_PINS];
  logic                mask_q  [NUM_PINS];
  logic                trig_q  [NUM_PINS];
  logic                pol_q   [NUM_PINS];
  logic                dlog_q  [NUM_PINS];
  logic                ds_q    [NUM_PINS];
  logic                remote_request_bit_q  [NUM_PINS];
  logic                prev_q  [NUM_PINS];
  logic [3:0]          id_q;
  logic [3:0]          arb_q;
  logic                reg_ack_q;
  logic [31:0]         reg_rdata_q;
  ioir_launch_t        state_q;
  logic [4:0]          scan_q;
  ioir_msg_t           msg_q;
  logic                msg_valid_q;
  logic                external_controller_delivery_q;
  logic                ext_ack_q;

  // ****************************************
  // Index decode
  // ****************************************
  wire logic [6:0]  ent_pin = 7'(link.reg_index[7:1] - 7'(`IOIR_IDX_TABLE >> 1));
  wire logic        ent_ok  = ioir_entry_hit(link.reg_index) && (int'(ent_pin) < NUM_PINS);
  wire logic [4:0]  rp      = ent_pin[4:0];
  wire logic        reg_wr  = link.reg_req & link.reg_wr;
  wire logic        wr_id   = reg_wr & (link.reg_index == `IOIR_IDX_ID);
  wire logic        wr_lo   = reg_wr & ent_ok & ~link.reg_index[0];
  wire logic        wr_hi   = reg_wr & ent_ok & link.reg_index[0];

  // ****************************************
  // Launcher decode
  // ****************************************
  wire logic        done     = (state_q == IOIR_ST_WAIT) & link.msg_accept;
  wire logic        launch   = (state_q == IOIR_ST_SCAN) & ds_q[scan_q];
  wire logic [4:0]  scan_nx  = (scan_q == 5'(NUM_PINS - 1)) ? 5'h00 : 5'(scan_q + 5'h01);
  wire ioir_mode_t  sc_mode  = mode_q[scan_q];
  wire logic        sc_fl    = (sc_mode == IOIR_FIXED) | (sc_mode == IOIR_LOWEST);
  wire logic        sc_novec = (sc_mode == IOIR_NMI) | (sc_mode == IOIR_INIT) | (sc_mode == IOIR_SMI);
  wire logic [7:0]  sc_dest  = dlog_q[scan_q] ? dest_q[scan_q] : {4'h0, dest_q[scan_q][3:0]};
  ioir_msg_t        next_msg;

  assign next_msg.vector   = sc_novec ? 8'h00 : vec_q[scan_q];
  assign next_msg.mode     = sc_mode;
  assign next_msg.dest     = sc_dest;
  assign next_msg.logical  = dlog_q[scan_q];
  assign next_msg.ext_dest = extended_destination_q[scan_q];
  assign next_msg.level    = trig_q[scan_q] & sc_fl;
  assign next_msg.pin      = {3'h0, scan_q};

  // ****************************************
  // Input synchroniser
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= irq_pins;
      sync2_q <= sync1_q;
    end
  end

  // ****************************************
  // Per-pin entries and detection
  // ****************************************
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    wire logic act      = sync2_q[g] ^ pol_q[g];
    wire logic fl       = (mode_q[g] == IOIR_FIXED) | (mode_q[g] == IOIR_LOWEST);
    wire logic ni       = (mode_q[g] == IOIR_NMI) | (mode_q[g] == IOIR_INIT);
    wire logic edge_hit = act & ~prev_q[g];
    // NMI and INIT entries on level keep re-arming, so the scan resends them
    wire logic lvl_hit  = trig_q[g] & act & (fl ? ~remote_request_bit_q[g] : ni);
    // Level fixed/lowest entries ignore edges, or a pin toggle would bypass the remote request
    wire logic set_ds   = ~mask_q[g] & ~ds_q[g] & ((edge_hit & ~(trig_q[g] & fl)) | lvl_hit);
    wire logic clr_ds   = done & (scan_q == 5'(g));
    wire logic set_remote_request_bit = clr_ds & trig_q[g] & fl;
    wire logic sel      = (ent_pin == 7'(g));
    wire logic clr_remote_request_bit = wr_lo & sel & ~link.reg_wdata[`IOIR_BIT_REMOTE_REQUEST_BIT];

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        vec_q[g]  <= 8'h00;
        mode_q[g] <= IOIR_FIXED;
        dest_q[g] <= 8'h00;
        extended_destination_q[g] <= 8'h00;
        mask_q[g] <= `IOIR_MASK_RESET;
        trig_q[g] <= 1'b0;
        pol_q[g]  <= 1'b0;
        dlog_q[g] <= 1'b0;
        ds_q[g]   <= 1'b0;
        remote_request_bit_q[g] <= 1'b0;
        prev_q[g] <= 1'b0;
      end else begin
        prev_q[g] <= act;
        ds_q[g]   <= set_ds | (ds_q[g] & ~clr_ds);
        remote_request_bit_q[g] <= set_remote_request_bit | (remote_request_bit_q[g] & ~clr_remote_request_bit);
        if (wr_lo && sel) begin
          vec_q[g]  <= link.reg_wdata[`IOIR_VEC_MSB:0];
          mode_q[g] <= ioir_mode_t'(link.reg_wdata[`IOIR_MODE_MSB:`IOIR_MODE_LSB]);
          dlog_q[g] <= link.reg_wdata[`IOIR_BIT_DLOG];
          pol_q[g]  <= link.reg_wdata[`IOIR_BIT_POL];
          trig_q[g] <= link.reg_wdata[`IOIR_BIT_TRIG];
          mask_q[g] <= link.reg_wdata[`IOIR_BIT_MASK];
        end
        if (wr_hi && sel) begin
          dest_q[g] <= link.reg_wdata[`IOIR_DEST_MSB:`IOIR_DEST_LSB];
          extended_destination_q[g] <= link.reg_wdata[`IOIR_EXTENDED_DESTINATION_MSB:`IOIR_EXTENDED_DESTINATION_LSB];
        end
      end
    end
  end

  // ****************************************
  // Message launcher
  // ****************************************
  // The scan stalls on the pin in flight so the acknowledge clears the right status bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= IOIR_ST_SCAN;
      scan_q      <= 5'h00;
      msg_q       <= '0;
      msg_valid_q <= 1'b0;
    end else begin
      unique case (state_q)
        IOIR_ST_SCAN: begin
          if (launch) begin
            state_q     <= IOIR_ST_WAIT;
            msg_q       <= next_msg;
            msg_valid_q <= 1'b1;
          end else begin
            scan_q <= scan_nx;
          end
        end
        IOIR_ST_WAIT: begin
          if (link.msg_accept) begin
            state_q     <= IOIR_ST_SCAN;
            msg_valid_q <= 1'b0;
            scan_q      <= scan_nx;
          end
        end
      endcase
    end
  end

  // ****************************************
  // External controller acknowledge
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      external_controller_delivery_q  <= 1'b0;
      ext_ack_q <= 1'b0;
    end else begin
      ext_ack_q <= link.interrupt_acknowledge_cycle & external_controller_delivery_q;
      if (done && msg_q.mode == IOIR_EXTERNAL_CONTROLLER_DELIVERY) begin
        external_controller_delivery_q <= 1'b1;
      end else if (link.interrupt_acknowledge_cycle) begin
        external_controller_delivery_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Identifier and arbitration
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      id_q  <= 4'h0;
      arb_q <= 4'h0;
    end else if (wr_id) begin
      id_q  <= link.reg_wdata[`IOIR_ID_MSB:`IOIR_ID_LSB];
      arb_q <= link.reg_wdata[`IOIR_ID_MSB:`IOIR_ID_LSB];
    end else if (link.arb_event) begin
      // Losers climb one step each round so every agent gets its turn
      arb_q <= link.arb_won ? 4'h0 : 4'(arb_q + 4'h1);
    end
  end

  // ****************************************
  // Register read path
  // ****************************************
  wire logic [31:0] lo_word = {15'h0000, mask_q[rp], trig_q[rp], remote_request_bit_q[rp], pol_q[rp],
                               ds_q[rp], dlog_q[rp], mode_q[rp], vec_q[rp]};
  wire logic [31:0] hi_word = {dest_q[rp], extended_destination_q[rp], 16'h0000};
  wire logic [31:0] id_word = {4'h0, id_q, 24'h00_0000};
  wire logic [31:0] ar_word = {4'h0, arb_q, 24'h00_0000};
  wire logic [31:0] rd_word = ent_ok ? (link.reg_index[0] ? hi_word : lo_word) :
                              (link.reg_index == `IOIR_IDX_ID)   ? id_word :
                              (link.reg_index == `IOIR_IDX_ARB)  ? ar_word :
                              (link.reg_index == `IOIR_IDX_BOOT) ? `IOIR_BOOT_VALUE :
                              32'h0000_0000;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_ack_q   <= 1'b0;
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      reg_ack_q <= link.reg_req;
      if (link.reg_req && !link.reg_wr) begin
        reg_rdata_q <= rd_word;
      end
    end
  end

  assign link.reg_ack   = reg_ack_q;
  assign link.reg_rdata = reg_rdata_q;
  assign link.msg_valid = msg_valid_q;
  assign link.msg       = msg_q;
  assign ext_ack        = ext_ack_q;

endmodule : ioir_redir_dev
`default_nettype wire

// *** ioir_defines.svh ***
// Constants shared by both ends of the redirection link
`ifndef IOIR_DEFINES_SVH
`define IOIR_DEFINES_SVH

// ****************************************
// Index map
// ****************************************
`define IOIR_NUM_PINS    24
`define IOIR_IDX_ID      8'h00
`define IOIR_IDX_ARB     8'h02
`define IOIR_IDX_BOOT    8'h03
`define IOIR_IDX_TABLE   8'h10
`define IOIR_IDX_LAST    8'h3F

// ****************************************
// Entry field positions, low word
// ****************************************
`define IOIR_BIT_MASK    16
`define IOIR_BIT_TRIG    15
`define IOIR_BIT_REMOTE_REQUEST_BIT    14
`define IOIR_BIT_POL     13
`define IOIR_BIT_DS      12
`define IOIR_BIT_DLOG    11
`define IOIR_MODE_MSB    10
`define IOIR_MODE_LSB    8
`define IOIR_VEC_MSB     7
`define IOIR_LO_RSV_LSB  17

// ****************************************
// Entry field positions, high word
// ****************************************
`define IOIR_DEST_MSB    31
`define IOIR_DEST_LSB    24
`define IOIR_EXTENDED_DESTINATION_MSB    23
`define IOIR_EXTENDED_DESTINATION_LSB    16
`define IOIR_HI_RSV_MSB  15

// ****************************************
// Identifier fields and reset values
// ****************************************
`define IOIR_ID_MSB      27
`define IOIR_ID_LSB      24
`define IOIR_BOOT_VALUE  32'h0000_0001
`define IOIR_MASK_RESET  1'b1
`define IOIR_VEC_MIN     8'h10
`define IOIR_VEC_MAX     8'hFE

`endif

// *** ioir_pkg.sv ***
// Types and index decoding shared by both ends
`include "ioir_defines.svh"
package ioir_pkg;

  typedef enum logic [2:0] {
    IOIR_FIXED  = 3'h0,
    IOIR_LOWEST = 3'h1,
    IOIR_SMI    = 3'h2,
    IOIR_RSV3   = 3'h3,
    IOIR_NMI    = 3'h4,
    IOIR_INIT   = 3'h5,
    IOIR_RSV6   = 3'h6,
    IOIR_EXTERNAL_CONTROLLER_DELIVERY = 3'h7
  } ioir_mode_t;

  typedef enum logic {
    IOIR_ST_SCAN,
    IOIR_ST_WAIT
  } ioir_launch_t;

  typedef struct packed {
    logic [7:0] vector;
    ioir_mode_t mode;
    logic [7:0] dest;
    logic       logical;
    logic [7:0] ext_dest;
    logic       level;
    logic [7:0] pin;
  } ioir_msg_t;

  // True for any index inside the redirection table window
  function automatic logic ioir_entry_hit(input logic [7:0] idx);
    ioir_entry_hit = (idx >= `IOIR_IDX_TABLE) && (idx <= `IOIR_IDX_LAST);
  endfunction : ioir_entry_hit

endpackage : ioir_pkg

// *** ioir_link_if.sv ***
// Link between the redirection block and the bus-side agent
`timescale 1ns/1ns
`default_nettype none
interface ioir_link_if;
  import ioir_pkg::*;

  logic            reg_req;
  logic            reg_wr;
  logic [7:0]      reg_index;
  logic [31:0]     reg_wdata;
  logic            reg_ack;
  logic [31:0]     reg_rdata;
  logic            msg_valid;
  ioir_msg_t       msg;
  logic            msg_accept;
  logic            arb_event;
  logic            arb_won;
  logic            interrupt_acknowledge_cycle;

  modport dev (
    input  reg_req, reg_wr, reg_index, reg_wdata, msg_accept, arb_event, arb_won, interrupt_acknowledge_cycle,
    output reg_ack, reg_rdata, msg_valid, msg
  );

  modport far (
    output reg_req, reg_wr, reg_index, reg_wdata, msg_accept, arb_event, arb_won, interrupt_acknowledge_cycle,
    input  reg_ack, reg_rdata, msg_valid, msg
  );
endinterface : ioir_link_if
`default_nettype wire

// *** ioir_redir_far.sv ***
// Bus-side agent: register access, message sink, arbitration events
`timescale 1ns/1ns
`default_nettype none
`include "ioir_defines.svh"
module ioir_redir_far
  import ioir_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Register command and response
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_index,
  input  wire logic [31:0] cmd_wdata,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata,
  // Delivered messages
  output logic             msg_out_valid,
  input  wire logic        msg_out_ready,
  output ioir_msg_t        msg_out,
  // Arbitration and acknowledge events
  input  wire logic        arb_event_in,
  input  wire logic        arb_won_in,
  input  wire logic        interrupt_acknowledge_cycle_in,
  // Link to the redirection block
  ioir_link_if.far         link
);

  // ****************************************
  // Write sanitising
  // ****************************************
  wire logic        is_ent = ioir_entry_hit(cmd_index);
  wire logic        is_lo  = is_ent & ~cmd_index[0];
  wire logic        is_hi  = is_ent & cmd_index[0];
  wire logic [2:0]  w_mode = cmd_wdata[`IOIR_MODE_MSB:`IOIR_MODE_LSB];
  wire logic        w_smi  = (w_mode == IOIR_SMI);
  wire logic [7:0]  w_vec  = cmd_wdata[`IOIR_VEC_MSB:0];
  // Out-of-range vectors are clamped rather than refused, so a write always completes
  wire logic [7:0]  c_vec  = w_smi ? 8'h00 :
                             (w_vec < `IOIR_VEC_MIN) ? `IOIR_VEC_MIN :
                             (w_vec > `IOIR_VEC_MAX) ? `IOIR_VEC_MAX : w_vec;
  wire logic [31:0] lo_w   = {15'h0000, cmd_wdata[`IOIR_BIT_MASK],
                              cmd_wdata[`IOIR_BIT_TRIG] & ~w_smi,
                              cmd_wdata[`IOIR_BIT_REMOTE_REQUEST_BIT:`IOIR_MODE_LSB], c_vec};
  wire logic [31:0] hi_w   = {cmd_wdata[31:`IOIR_HI_RSV_MSB+1], 16'h0000};
  wire logic [31:0] s_wdat = is_lo ? lo_w : (is_hi ? hi_w : cmd_wdata);

  logic        pend_q;
  logic        req_q;
  logic        wr_q;
  logic [7:0]  idx_q;
  logic [31:0] wdat_q;
  logic        rsp_valid_q;
  logic [31:0] rsp_rdata_q;
  logic        hold_q;
  ioir_msg_t   msg_hold_q;
  logic        arb_event_q;
  logic        arb_won_q;
  logic        interrupt_acknowledge_cycle_q;

  wire logic   take = cmd_valid & ~pend_q;

  // ****************************************
  // Register command path
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_q      <= 1'b0;
      req_q       <= 1'b0;
      wr_q        <= 1'b0;
      idx_q       <= 8'h00;
      wdat_q      <= 32'h0000_0000;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= 32'h0000_0000;
    end else begin
      req_q       <= take;
      rsp_valid_q <= link.reg_ack;
      if (take) begin
        pend_q <= 1'b1;
        wr_q   <= cmd_write;
        idx_q  <= cmd_index;
        wdat_q <= cmd_write ? s_wdat : 32'h0000_0000;
      end else if (link.reg_ack) begin
        pend_q <= 1'b0;
      end
      if (link.reg_ack) begin
        rsp_rdata_q <= link.reg_rdata;
      end
    end
  end

  // ****************************************
  // Message sink
  // ****************************************
  // Accept is withheld while a message waits, which stalls the launcher
  wire logic acc = link.msg_valid & ~hold_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_q     <= 1'b0;
      msg_hold_q <= '0;
    end else if (acc) begin
      hold_q     <= 1'b1;
      msg_hold_q <= link.msg;
    end else if (msg_out_ready) begin
      hold_q <= 1'b0;
    end
  end

  // ****************************************
  // Arbitration and acknowledge events
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      arb_event_q <= 1'b0;
      arb_won_q   <= 1'b0;
      interrupt_acknowledge_cycle_q      <= 1'b0;
    end else begin
      arb_event_q <= arb_event_in;
      arb_won_q   <= arb_won_in;
      interrupt_acknowledge_cycle_q      <= interrupt_acknowledge_cycle_in;
    end
  end

  assign cmd_ready       = ~pend_q;
  assign rsp_valid       = rsp_valid_q;
  assign rsp_rdata       = rsp_rdata_q;
  assign msg_out_valid   = hold_q;
  assign msg_out         = msg_hold_q;
  assign link.reg_req    = req_q;
  assign link.reg_wr     = wr_q;
  assign link.reg_index  = idx_q;
  assign link.reg_wdata  = wdat_q;
  assign link.msg_accept = acc;
  assign link.arb_event  = arb_event_q;
  assign link.arb_won    = arb_won_q;
  assign link.interrupt_acknowledge_cycle       = interrupt_acknowledge_cycle_q;

endmodule : ioir_redir_far
`default_nettype wire

// *** ioir_redir_assertions.sv ***
// Link checker for the redirection block and its bus-side agent
`timescale 1ns/1ns
`default_nettype none
module ioir_redir_assertions
  import ioir_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Register path
  input  wire logic        reg_req,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_index,
  input  wire logic        reg_ack,
  input  wire logic [31:0] reg_rdata,
  // Message path
  input  wire logic        msg_valid,
  input  wire ioir_msg_t   msg,
  input  wire logic        msg_accept
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ****
  // Properties
  // ****
  sequence s_rd(idx);
    reg_req && !reg_wr && reg_index == idx;
  endsequence
  sequence s_special;
    msg_valid && msg.mode inside {IOIR_SMI, IOIR_NMI, IOIR_INIT};
  endsequence

  a_ack_one_cycle: assert property (reg_req |=> reg_ack ##1 !reg_ack) else $error("ack timing");
  a_boot_reads_one: assert property (s_rd(8'h03) |=> reg_rdata == 32'h0000_0001) else $error("boot value");
  a_arb_rsv_zero: assert property (s_rd(8'h02) |=> reg_rdata[31:28] == 4'h0 && reg_rdata[23:0] == 24'h00_0000)
    else $error("arb reserved bits");
  a_msg_holds: assert property (msg_valid && !msg_accept |=> msg_valid && $stable(msg)) else $error("msg dropped");
  a_msg_drops: assert property (msg_valid && msg_accept |=> !msg_valid) else $error("msg repeated");
  a_accept_once: assert property (msg_accept |=> !msg_accept) else $error("double accept");
  a_vec_ignored: assert property (s_special |-> msg.vector == 8'h00) else $error("vector not ignored");
  a_special_edge: assert property (s_special |-> !msg.level) else $error("special mode level");
  a_ext_edge: assert property (msg_valid && msg.mode == IOIR_EXTERNAL_CONTROLLER_DELIVERY |-> !msg.level) else $error("ext level");
  a_phys_dest: assert property (msg_valid && !msg.logical |-> msg.dest[7:4] == 4'h0) else $error("phys dest");
  a_vec_range: assert property (msg_valid && msg.mode == IOIR_FIXED |-> msg.vector inside {[8'h10:8'hFE]})
    else $error("vector range");
endmodule : ioir_redir_assertions
`default_nettype wire

// *** io_interrupt_redirection_bench.sv ***
// Self-checking bench joining both ends of the redirection link
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module io_interrupt_redirection_bench;
  import ioir_pkg::*;
  logic        clk_sys = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0;
  logic        rdy = 1'b1, arb_ev = 1'b0, arb_w = 1'b0, interrupt_acknowledge_cycle = 1'b0;
  logic [7:0]  cmd_index = 8'h00;
  logic [31:0] cmd_wdata = 32'h0000_0000;
  logic [23:0] pins = 24'h00_0000;
  logic        cmd_ready, rsp_valid, ext_ack, msg_out_valid;
  logic [31:0] rsp_rdata;
  ioir_msg_t   msg_out;
  int          errors = 0, cmp_count = 0, seed = 97036, arb = 0;
  ioir_mode_t  modes [6] = '{IOIR_FIXED, IOIR_LOWEST, IOIR_SMI, IOIR_NMI, IOIR_INIT, IOIR_EXTERNAL_CONTROLLER_DELIVERY};

  always #50 clk_sys = ~clk_sys;

  ioir_link_if link ();
  ioir_redir_dev #(.NUM_PINS(24)) i_ioir_redir_dev (.clk_sys(clk_sys), .rst_n(rst_n), .irq_pins(pins),
    .ext_ack(ext_ack), .link(link));
  ioir_redir_far i_ioir_redir_far (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_index(cmd_index), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .msg_out_valid(msg_out_valid), .msg_out_ready(rdy), .msg_out(msg_out),
    .arb_event_in(arb_ev), .arb_won_in(arb_w), .interrupt_acknowledge_cycle_in(interrupt_acknowledge_cycle), .link(link));
  ioir_redir_assertions i_ioir_redir_assertions (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(link.reg_req),
    .reg_wr(link.reg_wr), .reg_index(link.reg_index), .reg_ack(link.reg_ack), .reg_rdata(link.reg_rdata),
    .msg_valid(link.msg_valid), .msg(link.msg), .msg_accept(link.msg_accept));

  // ****
  // Tasks and model
  // ****
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // Answer latency is fixed at two cycles after the take edge, seen on the third falling edge
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [31:0] exp);
    int n;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_index <= idx;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (n == 1) `CHK(cmd_ready, 1'b0)
    end while (rsp_valid !== 1'b1 && n < 8);
    `CHK(n, 3)
    `CHK(cmd_ready, 1'b1)
    if (!w) `CHK(rsp_rdata, exp)
  endtask : xfer

  task automatic arb_pulse(input logic w);
    @(posedge clk_sys);
    arb_ev <= 1'b1;
    arb_w <= w;
    @(posedge clk_sys);
    arb_ev <= 1'b0;
    arb = w ? 0 : (arb + 1) % 16;
    xfer(1'b0, 8'h02, '0, 32'(arb) << 24);
  endtask : arb_pulse

  // Window is longer than a full scan, so a missing message cannot slip past
  task automatic wait_msg(output logic got, output ioir_msg_t m);
    got = 1'b0;
    m = '0;
    repeat (60) begin
      @(negedge clk_sys);
      if (msg_out_valid === 1'b1 && !got) begin
        got = 1'b1;
        m = msg_out;
      end
    end
  endtask : wait_msg

  function automatic ioir_msg_t model(input int p, input logic [31:0] lo, input logic [31:0] hi);
    ioir_msg_t e;
    e.mode = ioir_mode_t'(lo[10:8]);
    e.vector = (lo[10:8] inside {3'h2, 3'h4, 3'h5}) ? 8'h00 : lo[7:0];
    e.logical = lo[11];
    e.dest = lo[11] ? hi[31:24] : {4'h0, hi[27:24]};
    e.ext_dest = hi[23:16];
    e.level = lo[15] && lo[10:9] == 2'b00;
    e.pin = 8'(p);
    return e;
  endfunction : model

  task automatic fire(input int p, input logic [31:0] lo, input logic [31:0] hi, input logic lvl, input logic want);
    logic        got;
    ioir_msg_t   m;
    logic [23:0] bm;
    bm = 24'h00_0001 << p;
    xfer(1'b1, 8'(17 + 2 * p), hi, '0);
    xfer(1'b1, 8'(16 + 2 * p), lo, '0);
    @(posedge clk_sys);
    pins <= lvl ? (pins | bm) : (pins & ~bm);
    wait_msg(got, m);
    `CHK(got, want)
    if (got) `CHK(m, model(p, lo, hi))
  endtask : fire

  initial begin
    #(10000 * 100);
    errors++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] lo, hi;
    logic        got;
    ioir_msg_t   m;
    int          p;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    xfer(1'b0, 8'h03, '0, 32'h0000_0001);
    xfer(1'b0, 8'h02, '0, 32'h0000_0000);
    xfer(1'b0, 8'h10, '0, 32'h0001_0000);
    xfer(1'b0, 8'h40, '0, 32'h0000_0000);
    xfer(1'b1, 8'h00, 32'hFFFF_FFFF, '0);
    arb = 15;
    xfer(1'b0, 8'h02, '0, 32'h0F00_0000);
    xfer(1'b1, 8'h02, 32'h0300_0000, '0);
    arb_pulse(1'b0);
    arb_pulse(1'b0);
    arb_pulse(1'b1);
    foreach (modes[i]) begin
      p = {$random(seed)} % 24;
      hi = $random(seed) & 32'hFFFF_0000;
      lo = {20'h0_0000, 1'($random(seed)), modes[i], 8'(16 + {$random(seed)} % 239)};
      fire(p, lo, hi, 1'b1, 1'b1);
      xfer(1'b0, 8'(16 + 2 * p), '0, (modes[i] == IOIR_SMI) ? {lo[31:8], 8'h00} : lo);
      @(posedge clk_sys);
      interrupt_acknowledge_cycle <= 1'b1;
      @(posedge clk_sys);
      interrupt_acknowledge_cycle <= 1'b0;
      repeat (2) @(negedge clk_sys);
      `CHK(ext_ack, modes[i] == IOIR_EXTERNAL_CONTROLLER_DELIVERY)
      xfer(1'b1, 8'(16 + 2 * p), lo | 32'h0001_0000, '0);
      @(posedge clk_sys);
      pins <= 24'h00_0000;
    end
    fire(5, 32'h0000_8040, '0, 1'b1, 1'b1);
    xfer(1'b0, 8'h1A, '0, 32'h0000_C040);
    // A fresh edge must not slip past the remote request
    @(posedge clk_sys);
    pins[5] <= 1'b0;
    repeat (4) @(posedge clk_sys);
    pins[5] <= 1'b1;
    wait_msg(got, m);
    `CHK(got, 1'b0)
    fire(5, 32'h0000_8040, '0, 1'b1, 1'b1);
    fire(5, 32'h0000_2050, '0, 1'b0, 1'b1);
    fire(5, 32'h0001_1050, '0, 1'b1, 1'b0);
    xfer(1'b0, 8'h1A, '0, 32'h0001_0050);
    fire(6, 32'h0000_8440, 32'h0300_0000, 1'b1, 1'b1);
    // Stall the sink so a level resend has to wait on the link
    @(posedge clk_sys);
    rdy <= 1'b0;
    repeat (60) @(posedge clk_sys);
    rdy <= 1'b1;
    wait_msg(got, m);
    `CHK(got, 1'b1)
    `CHK(m, model(6, 32'h0000_8440, 32'h0300_0000))
    tally_and_finish();
  end
endmodule : io_interrupt_redirection_bench
`default_nettype wire
